// File: include/regulator_pkg.sv
package regulator_pkg;

   // Core clock rate and the rounding used for timing counts.
   localparam int CORE_HZ = 10_000_000;
   localparam int CLK_NS = 100;

   function automatic int ns_to_cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Switching frequency per output option and the period in clocks.
   localparam int FSW_HZ_2V5 = 1_300_000;
   localparam int FSW_HZ_3V3 = 1_500_000;
   localparam int SW_PERIOD_2V5 = CORE_HZ / FSW_HZ_2V5;
   localparam int SW_PERIOD_3V3 = CORE_HZ / FSW_HZ_3V3;
   localparam int MIN_ON_NS = 100;
   localparam int MIN_OFF_NS = 200;
   localparam int MIN_ON_CYC = ns_to_cyc_up(MIN_ON_NS);
   localparam int MIN_OFF_CYC = ns_to_cyc_up(MIN_OFF_NS);

   // Reference ramp step interval for the two ramp-speed settings.
   localparam int SS_STEP_NS_FAST = 500;
   localparam int SS_STEP_NS_SLOW = 2000;
   localparam int SS_STEP_CYC_FAST = ns_to_cyc_up(SS_STEP_NS_FAST);
   localparam int SS_STEP_CYC_SLOW = ns_to_cyc_up(SS_STEP_NS_SLOW);

   // Memory load time after the bias rail comes up.
   localparam int NVM_LOAD_CYC = 16;

   // Register offsets, bit positions and load values.
   localparam logic [7:0] REG_TARGET_UPPER = 8'h12;
   localparam logic [7:0] REG_TARGET_LOWER = 8'h13;
   localparam logic [7:0] REG_GSTOP_REQ = 8'h14;
   localparam logic [7:0] REG_RAMP_RATE = 8'h15;
   localparam logic [7:0] REG_GSTOP_ARM = 8'h1C;
   localparam logic [7:0] REG_BASE_SELECT = 8'h20;
   localparam logic [7:0] REG_STATUS = 8'h21;
   localparam int TARGET_MSB_BIT = 0;
   localparam int GSTOP_REQ_BIT = 2;
   localparam int GSTOP_ARM_BIT = 3;
   localparam int RAMP_FAST_BIT = 0;
   localparam logic [7:0] BASE_ADDR_LOAD = 8'h08;

   typedef enum logic [1:0] {RAMP_HOLD, RAMP_UP, RAMP_DOWN, RAMP_ZERO}
      ramp_mode_t;

   // Strap resistance classes as reported by the address detector.
   typedef enum logic [1:0] {STRAP_SHORT, STRAP_10K, STRAP_20K, STRAP_OPEN}
      strap_class_t;

endpackage

// File: verilog/ramp_ref.sv
`timescale 1ns/10ps
module ramp_ref
   import regulator_pkg::*;
(
   // Clock and reset
   input logic core_clk,
   input logic reset,
   // Control
   input ramp_mode_t mode,
   input logic fast_rate,
   input logic [8:0] target,
   // Reference level
   output logic [8:0] level_q,
   output logic at_target,
   output logic at_zero
);
   logic [15:0] tick_q;
   logic [15:0] tick_end;
   logic step;

   assign tick_end = fast_rate ? 16'(SS_STEP_CYC_FAST - 1)
                               : 16'(SS_STEP_CYC_SLOW - 1);
   assign step = (tick_q == tick_end);
   assign at_target = (level_q == target);
   assign at_zero = (level_q == 9'h000);

   always_ff @(posedge core_clk) begin
      if (reset || mode == RAMP_ZERO || step) tick_q <= 16'h0000;
      else tick_q <= tick_q + 16'h0001;
   end

   // Rising mode tracks the target both ways so a new code is slewed too.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         level_q <= 9'h000;
      end else begin
         case (mode)
            RAMP_ZERO: level_q <= 9'h000;
            RAMP_UP: begin
               if (step && level_q < target) level_q <= level_q + 9'h001;
               else if (step && level_q > target) level_q <= level_q - 9'h001;
            end
            RAMP_DOWN: if (step && !at_zero) level_q <= level_q - 9'h001;
            default: level_q <= level_q;
         endcase
      end
   end
endmodule

// File: verilog/bus_target.sv
`timescale 1ns/10ps
module bus_target
   import regulator_pkg::*;
(
   // Clock and reset
   input logic core_clk,
   input logic reset,
   // Synchronised bus lines
   input logic scl_s,
   input logic sda_s,
   // Register side
   input logic accept,
   input logic [6:0] dev_addr,
   input logic [7:0] rd_data,
   output logic [7:0] ptr_q,
   output logic wr_stb_q,
   output logic [7:0] wr_data_q,
   // Data line drive
   output logic sda_oe_n_q
);
   typedef enum logic [3:0] {BS_IDLE, BS_ADDR, BS_ACK_A, BS_PTR, BS_ACK_P,
      BS_WDATA, BS_ACK_W, BS_RDATA, BS_RACK} bus_state_t;
   bus_state_t bs_q;
   logic scl_d1_q, sda_d1_q, rnw_q, mack_q;
   logic [7:0] sh_q;
   logic [3:0] cnt_q;
   logic rise, fall, start, stop;

   assign rise = scl_s & ~scl_d1_q;
   assign fall = ~scl_s & scl_d1_q;
   assign start = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
   assign stop = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

   always_ff @(posedge core_clk) begin
      scl_d1_q <= reset | scl_s;
      sda_d1_q <= reset | sda_s;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         bs_q <= BS_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         rnw_q <= 1'b0;
         mack_q <= 1'b0;
         ptr_q <= 8'h00;
         wr_stb_q <= 1'b0;
         wr_data_q <= 8'h00;
         sda_oe_n_q <= 1'b1;
      end else begin
         wr_stb_q <= 1'b0;
         if (start && accept) begin
            bs_q <= BS_ADDR;
            cnt_q <= 4'h0;
            sda_oe_n_q <= 1'b1;
         end else if (start || stop) begin
            bs_q <= BS_IDLE;
            sda_oe_n_q <= 1'b1;
         end else if (rise) begin
            if (bs_q == BS_RACK) begin
               mack_q <= ~sda_s;
               if (!sda_s) ptr_q <= ptr_q + 8'h01;
            end else if (bs_q inside {BS_ADDR, BS_PTR, BS_WDATA}) begin
               sh_q <= {sh_q[6:0], sda_s};
               cnt_q <= cnt_q + 4'h1;
            end
         end else if (fall) begin
            case (bs_q)
               BS_ADDR: if (cnt_q == 4'h8) begin
                  if (sh_q[7:1] == dev_addr) begin
                     sda_oe_n_q <= 1'b0;
                     rnw_q <= sh_q[0];
                     bs_q <= BS_ACK_A;
                  end else bs_q <= BS_IDLE;
               end
               BS_ACK_A: begin
                  cnt_q <= 4'h0;
                  if (rnw_q) begin
                     sh_q <= rd_data;
                     sda_oe_n_q <= rd_data[7];
                     bs_q <= BS_RDATA;
                  end else begin
                     sda_oe_n_q <= 1'b1;
                     bs_q <= BS_PTR;
                  end
               end
               BS_PTR: if (cnt_q == 4'h8) begin
                  sda_oe_n_q <= 1'b0;
                  ptr_q <= sh_q;
                  bs_q <= BS_ACK_P;
               end
               BS_ACK_P, BS_ACK_W: begin
                  if (bs_q == BS_ACK_W) ptr_q <= ptr_q + 8'h01;
                  sda_oe_n_q <= 1'b1;
                  cnt_q <= 4'h0;
                  bs_q <= BS_WDATA;
               end
               BS_WDATA: if (cnt_q == 4'h8) begin
                  sda_oe_n_q <= 1'b0;
                  wr_stb_q <= 1'b1;
                  wr_data_q <= sh_q;
                  bs_q <= BS_ACK_W;
               end
               BS_RDATA: if (cnt_q == 4'h7) begin
                  sda_oe_n_q <= 1'b1;
                  bs_q <= BS_RACK;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
                  sh_q <= {sh_q[6:0], 1'b0};
                  sda_oe_n_q <= sh_q[6];
               end
               BS_RACK: if (mack_q) begin
                  sh_q <= rd_data;
                  cnt_q <= 4'h0;
                  sda_oe_n_q <= rd_data[7];
                  bs_q <= BS_RDATA;
               end else bs_q <= BS_IDLE;
               default: bs_q <= BS_IDLE;
            endcase
         end
      end
   end
endmodule

// File: verilog/regulator_supervisor.sv
// Overview of operation
// - Base bus address register loads 0x08.
// - Bus address is base plus offset 0-3.
// - Strap class sampled once, mapped to offset.
// - After bias reset, load memory, resolve offset.
// - Ramp reference only after init and enable.
// - Target is 9-bit code across 0x12/0x13.
// - Fault detection stays active during ramp.
// - Pre-biased start: switches off until ramp passes.
// - Power-good waits for first high-side pulse.
// - Enable low kills drivers and ramp at once.
// - Gentle stop ramps down, then drivers off.
// - Arm and request bits are zero after init.
// - Switching period fixed by output option.
// - Very low output uses minimum on-time.
// - Low side conducts in off-time, is sensed.
// - Low-side overcurrent comparator raises fault.
// - Overcurrent drops ramp and power-good, drains.
// - Hiccup blanking with both off, then retry.
// - No bus traffic accepted before init done.
`timescale 1ns/10ps
module regulator_supervisor
   import regulator_pkg::*;
#(
   parameter int HICCUP_CYC = 2000,
   parameter logic [8:0] TARGET_LOAD = 9'h0FA
)(
   // Clock and reset
   input logic core_clk,
   input logic reset,
   // Two-wire bus pins
   input logic scl_in,
   input logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Control pins and sense comparators
   input logic enable_in,
   input logic [1:0] strap_class,
   input logic variant_3v3,
   input logic output_sense_low,
   input logic ref_above_sense,
   input logic overcurrent_guard,
   input logic ls_current_zero,
   input logic ov_trip,
   // Switch drivers and status
   output logic hs_gate,
   output logic ls_gate,
   output logic output_ok_flag,
   output logic [8:0] ref_level
);
   typedef enum logic [3:0] {ST_NVM_LOAD, ST_STRAP, ST_WAIT_EN, ST_PREBIAS,
      ST_RUN, ST_GSTOP, ST_STOPPED, ST_OC_DRAIN, ST_HICCUP, ST_OV_LATCH}
      state_t;
   localparam logic [10:0] SYNC_IDLE = 11'h600;

   state_t st_q, st_d;
   logic [10:0] sync1_q, sync2_q;
   logic scl_s, sda_s, en_s, variant_s, sense_low_s, above_s;
   logic oc_s, ls_zero_s, ov_s;
   strap_class_t strap_s;
   logic [7:0] upper_q, lower_q, req_reg_q, arm_reg_q, rate_q, base_q;
   logic [1:0] offset_q;
   logic init_done_q, first_pulse_q, sda_out_q;
   logic [3:0] period_q, sw_cnt_q;
   logic [4:0] nvm_cnt_q;
   logic [15:0] hic_cnt_q;
   logic [7:0] ptr, wr_data, rd_data;
   logic wr_stb, stop_req, oc_evt, hs_want, run_like;
   logic rmp_at_target, rmp_at_zero;
   logic [6:0] dev_addr;
   ramp_mode_t rmp_mode;

   function automatic logic [1:0] strap_to_offset(input strap_class_t c);
      case (c)
         STRAP_SHORT: return 2'h0;
         STRAP_10K: return 2'h1;
         STRAP_20K: return 2'h2;
         default: return 2'h3;
      endcase
   endfunction

   // Every pin passes two flops; the first stage feeds only the second.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sync1_q <= SYNC_IDLE;
         sync2_q <= SYNC_IDLE;
      end else begin
         sync1_q <= {scl_in, sda_in, enable_in, strap_class, variant_3v3,
                     output_sense_low, ref_above_sense, overcurrent_guard,
                     ls_current_zero, ov_trip};
         sync2_q <= sync1_q;
      end
   end
   assign scl_s = sync2_q[10];
   assign sda_s = sync2_q[9];
   assign en_s = sync2_q[8];
   assign strap_s = strap_class_t'(sync2_q[7:6]);
   assign variant_s = sync2_q[5];
   assign sense_low_s = sync2_q[4];
   assign above_s = sync2_q[3];
   assign oc_s = sync2_q[2];
   assign ls_zero_s = sync2_q[1];
   assign ov_s = sync2_q[0];

   assign stop_req = arm_reg_q[GSTOP_ARM_BIT] & req_reg_q[GSTOP_REQ_BIT];
   assign run_like = (st_q == ST_RUN) || (st_q == ST_GSTOP);
   // Only the off-time conduction interval is judged by the comparator.
   assign oc_evt = run_like && ls_gate && oc_s;
   assign dev_addr = 7'(base_q + {6'h00, offset_q});

   // A very low output gets only the minimum on-time each period.
   assign hs_want = (sw_cnt_q < 4'(MIN_ON_CYC)) ||
      (!sense_low_s && above_s &&
       sw_cnt_q < period_q - 4'(MIN_OFF_CYC));

   bus_target u_bus (
      .core_clk(core_clk),
      .reset(reset),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .accept(init_done_q),
      .dev_addr(dev_addr),
      .rd_data(rd_data),
      .ptr_q(ptr),
      .wr_stb_q(wr_stb),
      .wr_data_q(wr_data),
      .sda_oe_n_q(sda_oe_n)
   );

   ramp_ref u_ramp (
      .core_clk(core_clk),
      .reset(reset),
      .mode(rmp_mode),
      .fast_rate(rate_q[RAMP_FAST_BIT]),
      .target({upper_q[TARGET_MSB_BIT], lower_q}),
      .level_q(ref_level),
      .at_target(rmp_at_target),
      .at_zero(rmp_at_zero)
   );

   always_ff @(posedge core_clk) begin
      sda_out_q <= 1'b0;
   end
   assign sda_out = sda_out_q;

   // Working registers are rewritten from memory during the load phase.
   always_ff @(posedge core_clk) begin
      if (reset || st_q == ST_NVM_LOAD) begin
         base_q <= BASE_ADDR_LOAD;
         upper_q <= {7'h00, TARGET_LOAD[8]};
         lower_q <= TARGET_LOAD[7:0];
         req_reg_q <= 8'h00;
         arm_reg_q <= 8'h00;
         rate_q <= 8'h00;
      end else if (wr_stb) begin
         case (ptr)
            REG_TARGET_UPPER: upper_q <= wr_data;
            REG_TARGET_LOWER: lower_q <= wr_data;
            REG_GSTOP_REQ: req_reg_q <= wr_data;
            REG_GSTOP_ARM: arm_reg_q <= wr_data;
            REG_RAMP_RATE: rate_q <= wr_data;
            REG_BASE_SELECT: base_q <= wr_data;
            default: base_q <= base_q;
         endcase
      end
   end

   always_comb begin
      case (ptr)
         REG_TARGET_UPPER: rd_data = upper_q;
         REG_TARGET_LOWER: rd_data = lower_q;
         REG_GSTOP_REQ: rd_data = req_reg_q;
         REG_GSTOP_ARM: rd_data = arm_reg_q;
         REG_RAMP_RATE: rd_data = rate_q;
         REG_BASE_SELECT: rd_data = base_q;
         REG_STATUS: rd_data = {first_pulse_q, output_ok_flag, offset_q, st_q};
         default: rd_data = 8'h00;
      endcase
   end

   // The offset is taken once; later strap changes are ignored.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         offset_q <= 2'h0;
         period_q <= 4'h0;
         init_done_q <= 1'b0;
      end else if (st_q == ST_STRAP) begin
         offset_q <= strap_to_offset(strap_s);
         period_q <= variant_s ? 4'(SW_PERIOD_3V3)
                               : 4'(SW_PERIOD_2V5);
         init_done_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || st_q != ST_NVM_LOAD) nvm_cnt_q <= 5'h00;
      else nvm_cnt_q <= nvm_cnt_q + 5'h01;
   end

   always_ff @(posedge core_clk) begin
      if (reset || st_q != ST_HICCUP) hic_cnt_q <= 16'h0000;
      else hic_cnt_q <= hic_cnt_q + 16'h0001;
   end

   always_ff @(posedge core_clk) begin
      if (reset || !run_like || sw_cnt_q == period_q - 4'h1)
         sw_cnt_q <= 4'h0;
      else sw_cnt_q <= sw_cnt_q + 4'h1;
   end

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_NVM_LOAD:
            if (nvm_cnt_q == 5'(NVM_LOAD_CYC - 1)) st_d = ST_STRAP;
         ST_STRAP: st_d = ST_WAIT_EN;
         ST_WAIT_EN:
            if (en_s) st_d = stop_req ? ST_STOPPED : ST_PREBIAS;
         ST_PREBIAS:
            if (ov_s) st_d = ST_OV_LATCH;
            else if (above_s) st_d = ST_RUN;
         ST_RUN:
            if (oc_evt) st_d = ST_OC_DRAIN;
            else if (ov_s) st_d = ST_OV_LATCH;
            else if (stop_req) st_d = ST_GSTOP;
         ST_GSTOP:
            if (oc_evt) st_d = ST_OC_DRAIN;
            else if (ov_s) st_d = ST_OV_LATCH;
            else if (rmp_at_zero) st_d = ST_STOPPED;
         ST_STOPPED: if (!stop_req) st_d = ST_PREBIAS;
         ST_OC_DRAIN: if (ls_zero_s) st_d = ST_HICCUP;
         ST_HICCUP:
            if (hic_cnt_q == 16'(HICCUP_CYC - 1)) st_d = ST_PREBIAS;
         ST_OV_LATCH: st_d = ST_OV_LATCH;
         default: st_d = ST_NVM_LOAD;
      endcase
      if (init_done_q && !en_s) st_d = ST_WAIT_EN;
   end

   always_ff @(posedge core_clk) begin
      if (reset) st_q <= ST_NVM_LOAD;
      else st_q <= st_d;
   end

   // Ramp is forced to zero in the same cycle as the drivers drop.
   always_comb begin
      if (!en_s || oc_evt) begin
         rmp_mode = RAMP_ZERO;
      end else begin
         case (st_q)
            ST_PREBIAS, ST_RUN: rmp_mode = RAMP_UP;
            ST_GSTOP: rmp_mode = RAMP_DOWN;
            default: rmp_mode = RAMP_ZERO;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || !en_s) begin
         hs_gate <= 1'b0;
         ls_gate <= 1'b0;
      end else if (oc_evt || st_q == ST_OC_DRAIN) begin
         hs_gate <= 1'b0;
         ls_gate <= 1'b1;
      end else if (st_q == ST_OV_LATCH || (run_like && ov_s)) begin
         hs_gate <= 1'b0;
         ls_gate <= ov_s;
      end else if (run_like &&
                   !(st_q == ST_GSTOP && rmp_at_zero)) begin
         hs_gate <= hs_want;
         ls_gate <= ~hs_want;
      end else begin
         hs_gate <= 1'b0;
         ls_gate <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || !run_like) first_pulse_q <= 1'b0;
      else if (hs_gate) first_pulse_q <= 1'b1;
   end

   always_ff @(posedge core_clk) begin
      if (reset) output_ok_flag <= 1'b0;
      else output_ok_flag <= en_s && st_q == ST_RUN && first_pulse_q &&
         rmp_at_target && !oc_evt && !ov_s;
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_drain_done;
      st_q == ST_OC_DRAIN && ls_zero_s && en_s;
   endsequence
   sequence s_blank_entry;
      st_q == ST_HICCUP ##1 (!hs_gate && !ls_gate);
   endsequence

   a_bus_quiet_early: assert property (
      !init_done_q |-> sda_oe_n)
      else $error("bus answered before init");
   a_enable_kill: assert property (
      (init_done_q && !en_s) |=>
      (!hs_gate && !ls_gate && ref_level == 9'h000))
      else $error("enable low left drivers or ramp on");
   a_prebias_off: assert property (
      (st_q == ST_PREBIAS) |=> (!hs_gate && !ls_gate))
      else $error("switch on before ramp passed output");
   a_pg_after_pulse: assert property (
      output_ok_flag |-> first_pulse_q)
      else $error("power-good before first pulse");
   a_oc_response: assert property (
      (oc_evt && en_s) |=> (!output_ok_flag && !hs_gate && ls_gate &&
      st_q == ST_OC_DRAIN))
      else $error("overcurrent response wrong");
   a_hiccup_blank: assert property (
      s_drain_done |=> s_blank_entry)
      else $error("hiccup did not blank switches");
   a_hiccup_length: assert property (
      (st_q == ST_HICCUP && en_s && hic_cnt_q < 16'(HICCUP_CYC - 1))
      |=> st_q == ST_HICCUP)
      else $error("hiccup blanking cut short");
   a_stopped_zero: assert property (
      (st_q == ST_STOPPED) |-> (ref_level == 9'h000 && !hs_gate))
      else $error("drivers on after gentle stop");
   a_gstop_default: assert property (
      (st_q == ST_STRAP) |-> !stop_req)
      else $error("gentle stop armed after load");
   a_offset_hold: assert property (
      init_done_q |=> $stable(offset_q))
      else $error("address offset changed");
   a_base_load: assert property (
      (st_q == ST_STRAP) |-> (base_q == BASE_ADDR_LOAD))
      else $error("base address not loaded");
   a_wait_no_ramp: assert property (
      (st_q == ST_WAIT_EN) |=> ref_level == 9'h000)
      else $error("ramp moved before enable");
endmodule

// File: tb/bus_host_model.sv
`timescale 1ns/10ps
module bus_host_model (
   // Pacing clock
   input wire logic core_clk,
   // Device drive of the data line
   input wire logic sda_oe_n,
   // Bus lines
   output logic scl_in,
   output logic sda_in
);
   logic drv_q;
   // Both lines have pull-ups, so the data line is the AND of its drivers.
   assign sda_in = drv_q & sda_oe_n;
   initial begin
      drv_q = 1'b1;
      scl_in = 1'b1;
   end
   // Four core cycles a half period give the 800 ns bus clock.
   task automatic half();
      repeat (4) @(negedge core_clk);
   endtask
   task automatic start();
      drv_q = 1'b1;
      half();
      scl_in = 1'b1;
      half();
      drv_q = 1'b0;
      half();
      scl_in = 1'b0;
      half();
   endtask
   task automatic stop();
      drv_q = 1'b0;
      half();
      scl_in = 1'b1;
      half();
      drv_q = 1'b1;
      half();
   endtask
   task automatic xbit(input logic b, output logic s);
      drv_q = b;
      half();
      scl_in = 1'b1;
      half();
      s = sda_in;
      scl_in = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--)
         xbit(tx[i], rx[i]);
      xbit(ack_in, ack);
   endtask
endmodule

// File: tb/regulator_supervisor_tb_top.sv
`timescale 1ns/10ps
module regulator_supervisor_tb_top;
   import regulator_pkg::*;
   localparam int HIC = 20;
   localparam logic [8:0] TL = 9'h0FA;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic scl_in, sda_in, sda_out, sda_oe_n, a;
   logic ov_trip = 1'b0;
   logic enable_in = 1'b0;
   logic [1:0] strap_class = 2'h0;
   logic variant_3v3 = 1'b0, output_sense_low = 1'b1;
   logic ref_above_sense = 1'b0, overcurrent_guard = 1'b0;
   logic ls_current_zero = 1'b0;
   logic hs_gate, ls_gate, output_ok_flag;
   logic [8:0] ref_level;
   logic [6:0] dev;
   logic [7:0] rd_v, lo;
   int err_count = 0, checks_done = 0, seed = 95356, n;
   int regm[int];
   always #50 core_clk = ~core_clk;
   regulator_supervisor #(.HICCUP_CYC(HIC), .TARGET_LOAD(TL))
      i_regulator_supervisor (
      .core_clk(core_clk), .reset(reset), .scl_in(scl_in),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .enable_in(enable_in), .strap_class(strap_class),
      .variant_3v3(variant_3v3), .output_sense_low(output_sense_low),
      .ref_above_sense(ref_above_sense),
      .overcurrent_guard(overcurrent_guard),
      .ls_current_zero(ls_current_zero), .ov_trip(ov_trip),
      .hs_gate(hs_gate), .ls_gate(ls_gate),
      .output_ok_flag(output_ok_flag), .ref_level(ref_level));
   bus_host_model i_bus_host_model (.core_clk(core_clk),
      .sda_oe_n(sda_oe_n), .scl_in(scl_in), .sda_in(sda_in));
   task automatic chk(input string nm, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic do_reset();
      reset = 1'b1;
      repeat (20) @(negedge core_clk);
      reset = 1'b0;
      regm.delete();
      regm[8'h12] = TL[8];
      regm[8'h13] = TL[7:0];
      regm[8'h14] = 0;
      regm[8'h1C] = 0;
      regm[8'h20] = 8'h08;
   endtask
   task automatic probe(input logic [6:0] dv, output logic ak);
      logic [7:0] r;
      i_bus_host_model.start();
      i_bus_host_model.xfer({dv, 1'b0}, 1'b1, r, ak);
   endtask
   task automatic pstop(input logic [6:0] dv, input logic e);
      probe(dv, a);
      i_bus_host_model.stop();
      chk("address ack", 16'(e), 16'(a));
   endtask
   task automatic wr(input logic [7:0] p, d);
      logic [7:0] r;
      logic a0, a1, a2;
      probe(dev, a0);
      i_bus_host_model.xfer(p, 1'b1, r, a1);
      i_bus_host_model.xfer(d, 1'b1, r, a2);
      i_bus_host_model.stop();
      chk("write ack", 16'h0, 16'({a0, a1, a2}));
      regm[p] = d;
   endtask
   task automatic rd(input logic [7:0] p);
      logic [7:0] r;
      logic a0, a1, a2;
      probe(dev, a0);
      i_bus_host_model.xfer(p, 1'b1, r, a1);
      i_bus_host_model.start();
      i_bus_host_model.xfer({dev, 1'b1}, 1'b1, r, a2);
      chk("read ack", 16'h0, 16'({a0, a1, a2}));
      i_bus_host_model.xfer(8'hFF, 1'b1, rd_v, a0);
      i_bus_host_model.stop();
      chk("register", 16'(regm.exists(p) ? regm[p] : 0), 16'(rd_v));
   endtask
   initial begin
      // Covers the whole sequence with a wide margin.
      #8_000_000;
      err_count++;
      end_sim();
   end
   initial begin
      @(negedge core_clk);
      // The output option is factory-fixed, so it is chosen before reset.
      variant_3v3 = 1'($random(seed));
      for (int k = 0; k < 4; k++) begin
         strap_class = 2'(k);
         do_reset();
         dev = 7'(8 + k);
         pstop(dev, 1'b1);
         pstop(dev, 1'b0);
         pstop(7'(dev + 4), 1'b1);
         strap_class = ~strap_class;
         pstop(dev, 1'b0);
      end
      $display("test address offset done");
      rd(8'h20);
      rd(8'h12);
      rd(8'h13);
      rd(8'h14);
      rd(8'h1C);
      rd(8'h30);
      chk("data out level", 16'h0, 16'(sda_out));
      $display("test register defaults done");
      lo = 8'hC8 + 8'($random(seed) & 31);
      wr(8'h12, 8'h00);
      wr(8'h13, lo);
      wr(8'h15, 8'h01);
      rd(8'h13);
      chk("ref before enable", 16'h0, 16'(ref_level));
      enable_in = 1'b1;
      n = 0;
      repeat (1400) if (ref_level !== {1'b0, lo}) begin
         n++;
         @(negedge core_clk);
      end
      chk("ramp time", 16'h1, 16'(n >= 5 * lo && n <= 5 * lo + 8));
      chk("prebias off", 16'h0, 16'({hs_gate, ls_gate}));
      chk("prebias ok", 16'h0, 16'(output_ok_flag));
      ref_above_sense = 1'b1;
      output_sense_low = 1'b0;
      repeat (20) if (hs_gate !== 1'b1) @(negedge core_clk);
      chk("first pulse", 16'h1, 16'(hs_gate));
      repeat (30) if (output_ok_flag !== 1'b1) @(negedge core_clk);
      chk("output ok", 16'h1, 16'(output_ok_flag));
      repeat (20) if (hs_gate !== 1'b0) @(negedge core_clk);
      repeat (20) if (hs_gate !== 1'b1) @(negedge core_clk);
      n = 0;
      repeat (20) if (hs_gate === 1'b1) begin
         n++;
         @(negedge core_clk);
      end
      repeat (20) if (hs_gate === 1'b0) begin
         n++;
         @(negedge core_clk);
      end
      chk("switch period", 16'(variant_3v3 ? SW_PERIOD_3V3 : SW_PERIOD_2V5),
          16'(n));
      $display("test ramp and prebias done");
      overcurrent_guard = 1'b1;
      repeat (16) @(negedge core_clk);
      overcurrent_guard = 1'b0;
      repeat (10) @(negedge core_clk);
      chk("oc drain", 16'h400, 16'({hs_gate, ls_gate, output_ok_flag,
          ref_level}));
      ls_current_zero = 1'b1;
      repeat (5) if (ls_gate !== 1'b0) @(negedge core_clk);
      n = 0;
      repeat (60) if (hs_gate === 1'b0 && ls_gate === 1'b0) begin
         n++;
         @(negedge core_clk);
      end
      ls_current_zero = 1'b0;
      chk("hiccup", 16'h1, 16'(n >= HIC && n <= HIC + 12));
      repeat (1400) if (output_ok_flag !== 1'b1) @(negedge core_clk);
      chk("restart ok", 16'h1, 16'(output_ok_flag));
      $display("test overcurrent done");
      wr(8'h1C, 8'h08);
      wr(8'h14, 8'h04);
      n = 0;
      repeat (1400) if (ref_level !== 9'h000) begin
         if (hs_gate || ls_gate)
            n++;
         @(negedge core_clk);
      end
      chk("switching in descent", 16'h1, 16'(n > 0));
      repeat (3) @(negedge core_clk);
      chk("stopped", 16'h0, 16'({hs_gate, ls_gate, ref_level}));
      wr(8'h15, 8'h00);
      wr(8'h14, 8'h00);
      n = 0;
      repeat (5000) if (output_ok_flag !== 1'b1) begin
         n++;
         @(negedge core_clk);
      end
      chk("restart after stop", 16'h1, 16'(output_ok_flag));
      chk("slow ramp time", 16'h1,
          16'(n + 40 >= 20 * lo && n <= 20 * lo + 8));
      $display("test gentle stop done");
      enable_in = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("hard off", 16'h0, 16'({hs_gate, ls_gate, output_ok_flag,
          ref_level}));
      $display("test hard shutdown done");
      enable_in = 1'b1;
      repeat (10) @(negedge core_clk);
      ov_trip = 1'b1;
      repeat (5) @(negedge core_clk);
      chk("ov in ramp", 16'h2, 16'({hs_gate, ls_gate, output_ok_flag}));
      ov_trip = 1'b0;
      repeat (5) @(negedge core_clk);
      chk("ov latched", 16'h0, 16'({hs_gate, ls_gate, ref_level}));
      enable_in = 1'b0;
      $display("test overvoltage done");
      end_sim();
   end
endmodule
